// [dv/iak_chk_monitor.sv]
// checker for the handler's acknowledge cycle pins
`timescale 1ns/1ps
module iak_chk (
  input wire       clk,
  input wire       sys_rst,
  input wire       as_n_q,
  input wire       ds0_n_q,
  input wire       ds1_n_q,
  input wire       write_n_q,
  input wire       iack_n_q,
  input wire       lword_n_q,
  input wire [2:0] addr_q,
  input wire       dtack_n,
  input wire       berr_n
);
  reg got_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // an acknowledge seen since AS* fell frees the handler
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) got_q <= 1'b0;
    else got_q <= !as_n_q && (got_q || !dtack_n || !berr_n);
  a_second_with_first: assert property ($fell(ds1_n_q) |-> $fell(ds0_n_q))
    else $error("second strobe late");
  a_level_held: assert property (!as_n_q && !got_q |-> $stable(addr_q))
    else $error("level code moved");
  a_as_held: assert property (!as_n_q && !got_q |=> !as_n_q)
    else $error("as released early");
  a_first_held: assert property (!ds0_n_q && !got_q |=> !ds0_n_q)
    else $error("first strobe released early");
  a_write_high: assert property (!ds0_n_q || !ds1_n_q |-> write_n_q)
    else $error("write low in cycle");
  a_acks_clear: assert property ($fell(ds0_n_q) || $fell(ds1_n_q) |-> $past(dtack_n && berr_n))
    else $error("strobe before acks high");
  a_lword_held: assert property (!as_n_q && !got_q |-> $stable(lword_n_q) && !iack_n_q)
    else $error("lword or iack moved");
  a_iack_up: assert property ($rose(as_n_q) |-> iack_n_q)
    else $error("iack low at as rise");
  a_iack_gap: assert property ($rose(iack_n_q) |=> iack_n_q [*6])
    else $error("iack high time short");
endmodule // iak_chk
bind iak_handler iak_chk chk_u (.clk(clk), .sys_rst(sys_rst), .as_n_q(as_n_q),
  .ds0_n_q(ds0_n_q), .ds1_n_q(ds1_n_q), .write_n_q(write_n_q), .iack_n_q(iack_n_q),
  .lword_n_q(lword_n_q), .addr_q(addr_q), .dtack_n(dtack_n), .berr_n(berr_n));

// [dv/iak_intr_model.sv]
// interrupter model answering the handler's acknowledge cycles
`timescale 1ns/1ps
module iak_intr_model (
  input  wire        clk,
  input  wire        as_n,
  input  wire        ds0_n,
  input  wire        ds1_n,
  input  wire        iack_n,
  input  wire [2:0]  addr,
  input  wire [2:0]  lvl,
  input  wire        use_berr,
  input  wire [7:0]  dly,
  input  wire [31:0] vec,
  output reg         dtack_n = 1'b1,
  output reg         berr_n = 1'b1,
  output wire [31:0] data
);
  reg       drive_q = 1'b0;
  reg [7:0] cnt_q = 8'h00;
  reg       pass_n  = 1'b1;
  // a slot not at lvl passes the acknowledge on once its own data is off
  always @(posedge clk) pass_n <= as_n || iack_n || ds0_n || drive_q || addr == lvl;
  // request pending only at lvl; iack_n doubles as this slot's chain input
  wire sel = !as_n && !iack_n && !ds0_n && addr == lvl;
  // floated lanes show the inverse so stale data cannot pass
  assign data = !drive_q ? ~vec : !ds1_n ? vec : {~vec[31:8], vec[7:0]};
  always @(posedge clk)
    if (!dtack_n || !berr_n) begin
      if (ds0_n && ds1_n && drive_q) drive_q <= 1'b0;
      else if (ds0_n && ds1_n) begin
        dtack_n <= 1'b1;
        berr_n <= 1'b1;
      end
    end else if (sel) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == dly + 8'h01) drive_q <= !use_berr;
      if (cnt_q == dly + 8'h02) begin
        dtack_n <= use_berr;
        berr_n <= !use_berr;
      end
    end else cnt_q <= 8'h00;
endmodule // iak_intr_model

// [dv/tb_top.sv]
// testbench for the acknowledge cycle handler
`timescale 1ns/1ps
module tb_top;
  reg         clk, sys_rst, ack_req, use_berr;
  reg  [2:0]  ack_level;
  reg  [1:0]  ack_width;
  reg  [7:0]  dly;
  reg  [31:0] vec, rnd;
  reg  [32:0] e;
  reg  [32:0] expq[$];
  wire        busy_q, done_q, berr_seen_q, as_n_q, as_oe_q, ds0_n_q, ds1_n_q, write_n_q;
  wire        iack_n_q, lword_n_q, ctl_oe_q, dtack_n, berr_n;
  wire [2:0]  addr_q;
  wire [31:0] vector_q, data;
  integer     n_fail = 0, checked = 0, cyc = 0, i;
  iak_handler dut_u (.clk(clk), .sys_rst(sys_rst), .ack_req(ack_req), .ack_level(ack_level),
    .ack_width(ack_width), .busy_q(busy_q), .done_q(done_q), .berr_seen_q(berr_seen_q),
    .vector_q(vector_q), .as_n_q(as_n_q), .as_oe_q(as_oe_q), .ds0_n_q(ds0_n_q),
    .ds1_n_q(ds1_n_q), .write_n_q(write_n_q), .iack_n_q(iack_n_q), .lword_n_q(lword_n_q),
    .addr_q(addr_q), .ctl_oe_q(ctl_oe_q), .dtack_n(dtack_n), .berr_n(berr_n), .data_in(data));
  // released backplane lines sit at their pull-up level
  iak_intr_model part_u (.clk(clk), .as_n(as_oe_q ? as_n_q : 1'b1),
    .ds0_n(ctl_oe_q ? ds0_n_q : 1'b1), .ds1_n(ctl_oe_q ? ds1_n_q : 1'b1),
    .iack_n(ctl_oe_q ? iack_n_q : 1'b1), .addr(ctl_oe_q ? addr_q : 3'h7), .lvl(ack_level),
    .use_berr(use_berr), .dly(dly), .vec(vec), .dtack_n(dtack_n), .berr_n(berr_n), .data(data));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task cmp32(input string nm, input [31:0] ex, input [31:0] s);
    begin
      checked = checked + 1;
      if (s !== ex) begin
        n_fail = n_fail + 1;
        $display("unexpected %s expected %h seen %h", nm, ex, s);
      end
    end
  endtask
  task cmp1(input string nm, input ex, input s);
    cmp32(nm, {31'h0, ex}, {31'h0, s});
  endtask
  task results;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // one cycle; a second request while busy must be ignored
  task run(input [1:0] w, input b, input [7:0] d);
    reg [31:0] m;
    begin
      rnd = xs(rnd);
      m = (w == 2'h3) ? 32'hffff_ffff : (w == 2'h2) ? 32'h0000_ffff : 32'h0000_00ff;
      @(negedge clk);
      ack_req = 1'b1;
      ack_width = w;
      ack_level = rnd[2:0];
      vec = rnd;
      use_berr = b;
      dly = d;
      expq.push_back({b, b ? 32'h0000_0000 : rnd & m});
      @(negedge clk);
      ack_req = 1'b0;
      @(negedge clk);
      ack_req = 1'b1;
      @(negedge clk);
      ack_req = 1'b0;
      while (busy_q !== 1'b0) @(negedge clk);
    end
  endtask
  always @(negedge clk)
    if (done_q === 1'b1) begin
      if (expq.size() == 0) cmp1("spare done", 1'b0, 1'b1);
      else begin
        e = expq.pop_front();
        cmp32("vector", e[31:0], vector_q);
        cmp1("bus error", e[32], berr_seen_q);
      end
    end
  // a hang with no acknowledge is cut off here
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    ack_req = 1'b0;
    ack_level = 3'h0;
    ack_width = 2'h0;
    use_berr = 1'b0;
    dly = 8'h00;
    vec = 32'h0000_0000;
    rnd = 32'h0001_85cc;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    for (i = 0; i < 4; i = i + 1) run(i[1:0], 1'b0, 8'h00);
    run(2'h3, 1'b1, 8'h00);
    for (i = 0; i < 8; i = i + 1) run(rnd[9:8], rnd[12], rnd[7:0] & 8'h1f);
    cmp32("left over", 32'h0000_0000, expq.size());
    results;
  end
endmodule // tb_top

// [verilog/iak_dly.v]
// delay counter used to pace the handler's edges
`timescale 1ns/1ps
module iak_dly #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         load,
  input  wire [W-1:0] count,
  output reg          done_q
);
  reg [W-1:0] cnt_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= {W{1'b0}};
      done_q <= 1'b1;
    end else if (load) begin
      cnt_q  <= count;
      done_q <= (count <= {{(W-1){1'b0}}, 1'b1});
    end else if (!done_q) begin
      cnt_q  <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      done_q <= (cnt_q <= {{(W-2){1'b0}}, 2'b10});
    end
  end
endmodule // iak_dly

// [verilog/iak_handler.v]
// interrupt handler side of the backplane acknowledge cycle
`timescale 1ns/1ps
`include "iak_map.vh"
module iak_handler #(
  parameter CW = 8
) (
  input  wire        clk,
  input  wire        sys_rst,
  // command port
  input  wire        ack_req,
  input  wire [2:0]  ack_level,
  input  wire [1:0]  ack_width,
  output reg         busy_q,
  output reg         done_q,
  output reg         berr_seen_q,
  output reg  [31:0] vector_q,
  // backplane pins, low active where the name says so
  output reg         as_n_q,
  output reg         as_oe_q,
  output reg         ds0_n_q,
  output reg         ds1_n_q,
  output reg         write_n_q,
  output reg         iack_n_q,
  output reg         lword_n_q,
  output reg  [2:0]  addr_q,
  output reg         ctl_oe_q,
  input  wire        dtack_n,
  input  wire        berr_n,
  input  wire [31:0] data_in
);

  // ************************************************************
  // timing counts
  // ************************************************************
  // least times round up, never below one cycle
  function [CW-1:0] fn_cyc_min;
    input integer ns;
    reg [31:0] t;
    begin
      t = (ns + `IAK_CLK_NS - 1) / `IAK_CLK_NS;
      if (t == 32'h0000_0000)
        t = 32'h0000_0001;
      fn_cyc_min = t[CW-1:0];
    end
  endfunction

  // keeps only the byte lanes the cycle asked for
  function [31:0] fn_lane_mask;
    input [1:0] w;
    begin
      case (w)
        `IAK_W_BYTE: fn_lane_mask = 32'h0000_00ff;
        `IAK_W_WORD: fn_lane_mask = 32'h0000_ffff;
        default:     fn_lane_mask = 32'hffff_ffff;
      endcase
    end
  endfunction

  localparam [CW-1:0] C_SETUP = fn_cyc_min(`IAK_ADDR_SETUP_NS);
  localparam [CW-1:0] C_AS_DS = fn_cyc_min(`IAK_AS_TO_DS_NS);
  localparam [CW-1:0] C_DVAL  = fn_cyc_min(`IAK_DATA_VALID_NS);
  localparam [CW-1:0] C_WHOLD = fn_cyc_min(`IAK_WRITE_HOLD_NS);
  localparam [CW-1:0] C_GAP   = fn_cyc_min(`IAK_AS_HIGH_NS);

  // ************************************************************
  // states
  // ************************************************************
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_CLR   = 4'h1;
  localparam [3:0] S_ASET  = 4'h2;
  localparam [3:0] S_ASL   = 4'h3;
  localparam [3:0] S_ACK   = 4'h4;
  localparam [3:0] S_DVAL  = 4'h5;
  localparam [3:0] S_REL   = 4'h6;
  localparam [3:0] S_WHOLD = 4'h7;
  localparam [3:0] S_ASUP  = 4'h8;
  localparam [3:0] S_GAP   = 4'h9;

  reg  [3:0]    state_q;
  reg  [1:0]    width_q;
  reg           dly_load;
  reg  [CW-1:0] dly_count;
  wire          dly_done;

  iak_dly #(
    .W       (CW)
  ) u_dly (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (dly_load),
    .count   (dly_count),
    .done_q  (dly_done)
  );

  wire acks_high = dtack_n & berr_n;

  // ************************************************************
  // delay requests
  // ************************************************************
  always @* begin
    dly_load  = 1'b0;
    dly_count = C_SETUP;
    case (state_q)
      S_CLR: begin
        dly_load  = acks_high;
        dly_count = C_SETUP;
      end
      S_ASET: begin
        dly_load  = dly_done;
        dly_count = C_AS_DS;
      end
      S_ACK: begin
        dly_load  = ~dtack_n;
        dly_count = C_DVAL;
      end
      S_REL: begin
        dly_load  = 1'b1;
        dly_count = C_WHOLD;
      end
      S_ASUP: begin
        dly_load  = 1'b1;
        dly_count = C_GAP;
      end
      default: begin
        dly_load  = 1'b0;
        dly_count = C_SETUP;
      end
    endcase
  end

  // ************************************************************
  // cycle sequencer
  // ************************************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= S_IDLE;
      width_q     <= `IAK_W_BYTE;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      berr_seen_q <= 1'b0;
      vector_q    <= 32'h0000_0000;
      as_n_q      <= 1'b1;
      as_oe_q     <= 1'b0;
      ds0_n_q     <= 1'b1;
      ds1_n_q     <= 1'b1;
      write_n_q   <= 1'b1;
      iack_n_q    <= 1'b1;
      lword_n_q   <= 1'b1;
      addr_q      <= 3'h0;
      ctl_oe_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // commands while busy are dropped, not queued
          if (ack_req) begin
            busy_q      <= 1'b1;
            berr_seen_q <= 1'b0;
            width_q     <= (ack_width == 2'h0) ? `IAK_W_BYTE : ack_width;
            addr_q      <= ack_level;
            state_q     <= S_CLR;
          end
        end
        S_CLR: begin
          // a slow responder may still hold its acknowledge from before
          if (acks_high) begin
            iack_n_q  <= 1'b0;
            lword_n_q <= (width_q != `IAK_W_QUAD);
            write_n_q <= 1'b1;
            ctl_oe_q  <= 1'b1;
            as_oe_q   <= 1'b1;
            state_q   <= S_ASET;
          end
        end
        S_ASET: begin
          if (dly_done) begin
            as_n_q  <= 1'b0;
            state_q <= S_ASL;
          end
        end
        S_ASL: begin
          // both strobes fall together for word and quad cycles, well inside the second's limit; byte cycles drop DS0* only
          if (dly_done) begin
            ds0_n_q <= 1'b0;
            ds1_n_q <= (width_q == `IAK_W_BYTE);
            state_q <= S_ACK;
          end
        end
        S_ACK: begin
          // no local timeout: the bus timer answers with BERR*
          if (!dtack_n) begin
            state_q <= S_DVAL;
          end else if (!berr_n) begin
            berr_seen_q <= 1'b1;
            vector_q    <= 32'h0000_0000;
            state_q     <= S_REL;
          end
        end
        S_DVAL: begin
          if (dly_done) begin
            vector_q <= data_in & fn_lane_mask(width_q);
            state_q  <= S_REL;
          end
        end
        S_REL: begin
          ds0_n_q <= 1'b1;
          ds1_n_q <= 1'b1;
          state_q <= S_WHOLD;
        end
        S_WHOLD: begin
          // WRITE* and the level stay driven past the strobes
          if (dly_done && acks_high) begin
            ctl_oe_q  <= 1'b0;
            iack_n_q  <= 1'b1;
            lword_n_q <= 1'b1;
            state_q   <= S_ASUP;
          end
        end
        S_ASUP: begin
          as_n_q  <= 1'b1;
          done_q  <= 1'b1;
          state_q <= S_GAP;
        end
        S_GAP: begin
          as_oe_q <= 1'b0;
          // IACK* stays high through the whole gap
          if (dly_done) begin
            busy_q  <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // iak_handler

// [verilog/iak_map.vh]
// constants for the interrupt acknowledge handler
`ifndef IAK_MAP_VH
`define IAK_MAP_VH

// ************************************************************
// clock and timing figures, in ns
// ************************************************************
`define IAK_CLK_NS        8
`define IAK_ADDR_SETUP_NS 35
`define IAK_AS_TO_DS_NS   40
`define IAK_DATA_VALID_NS 25
`define IAK_WRITE_HOLD_NS 10
`define IAK_AS_HIGH_NS    40

// ************************************************************
// byte width codes on the command port
// ************************************************************
`define IAK_W_BYTE 2'h1
`define IAK_W_WORD 2'h2
`define IAK_W_QUAD 2'h3

`endif
